// [ssl_pkg.sv]
// shared constants for the synthesizer serial load port
package ssl_pkg;
  // word and select layout
  localparam int SSL_WORD_W = 24;
  localparam int SSL_SEL_W = 3;
  localparam int SSL_NUM_HOLD = 7;
  localparam logic [2:0] SSL_SEL_RF_N = 3'h0;
  localparam logic [2:0] SSL_SEL_RF_R = 3'h1;
  localparam logic [2:0] SSL_SEL_RF_CTRL = 3'h2;
  localparam logic [2:0] SSL_SEL_MASTER = 3'h3;
  localparam logic [2:0] SSL_SEL_IF_N = 3'h4;
  localparam logic [2:0] SSL_SEL_IF_R = 3'h5;
  localparam logic [2:0] SSL_SEL_IF_CTRL = 3'h6;
  localparam logic [2:0] SSL_SEL_NONE = 3'h7;
  // fractional feedback divider word
  localparam int SSL_RESV_BIT = 23;
  localparam int SSL_INT_LSB = 15;
  localparam int SSL_INT_W = 8;
  localparam int SSL_FRAC_LSB = 3;
  localparam int SSL_FRAC_W = 12;
  // fractional reference divider word
  localparam int SSL_DENOM_LSB = 3;
  localparam int SSL_DENOM_W = 12;
  localparam int SSL_RRF_LSB = 15;
  localparam int SSL_RRF_W = 4;
  localparam int SSL_RF_DBL_BIT = 19;
  localparam int SSL_RF_PRE_BIT = 20;
  // control words
  localparam int SSL_CTRL_LSB = 3;
  localparam int SSL_CTRL_W = 13;
  // master word
  localparam int SSL_MUX_LSB = 7;
  localparam int SSL_MUX_W = 4;
  localparam int SSL_XO_BIT = 6;
  localparam int SSL_PD_BIT = 5;
  localparam int SSL_CP3_BIT = 4;
  localparam int SSL_CRST_BIT = 3;
  // integer feedback divider word
  localparam int SSL_A_LSB = 3;
  localparam int SSL_A_W = 6;
  localparam int SSL_B_LSB = 9;
  localparam int SSL_B_W = 12;
  localparam int SSL_IPRE_LSB = 21;
  localparam int SSL_IPRE_W = 2;
  localparam int SSL_NRATIO_W = 19;
  // integer reference divider word
  localparam int SSL_RIF_LSB = 3;
  localparam int SSL_RIF_W = 15;
  localparam int SSL_IF_DBL_BIT = 18;
  // output select codes
  localparam logic [3:0] SSL_MUX_RF_DLD = 4'h0;
  localparam logic [3:0] SSL_MUX_RF_ALD = 4'h1;
  localparam logic [3:0] SSL_MUX_IF_DLD = 4'h2;
  localparam logic [3:0] SSL_MUX_IF_ALD = 4'h3;
  localparam logic [3:0] SSL_MUX_RF_DIV = 4'h4;
  localparam logic [3:0] SSL_MUX_IF_DIV = 4'h5;
  localparam logic [3:0] SSL_MUX_REF_DIV = 4'h6;
  localparam logic [SSL_WORD_W-1:0] SSL_HOLD_RESET = 24'h000000;
  // controller registers
  localparam int SSL_ADDR_W = 4;
  localparam logic [3:0] SSL_REG_DATA = 4'h0;
  localparam logic [3:0] SSL_REG_CTRL = 4'h4;
  localparam logic [3:0] SSL_REG_STATUS = 4'h8;
  localparam int SSL_START_BIT = 0;
  localparam int SSL_LEN_LSB = 8;
  localparam int SSL_LEN_W = 5;
  localparam logic [4:0] SSL_LEN_RESET = 5'h18;
  localparam int SSL_BUSY_BIT = 0;
  localparam int SSL_DONE_BIT = 1;
  localparam int SSL_PIN_BIT = 2;
  // timing
  localparam int SSL_SYS_PERIOD_NS = 10;
  localparam int SSL_SCLK_HALF_NS = 50;
  localparam int SSL_STB_HIGH_NS = 50;
  localparam int SSL_SCLK_HALF_CYC =
    (SSL_SCLK_HALF_NS + SSL_SYS_PERIOD_NS - 1) / SSL_SYS_PERIOD_NS;
  localparam int SSL_STB_HIGH_CYC =
    (SSL_STB_HIGH_NS + SSL_SYS_PERIOD_NS - 1) / SSL_SYS_PERIOD_NS;

  // integer side prescaler modulus from its two-bit code
  function automatic logic [6:0] ssl_presc(input logic [1:0] code);
    case (code)
      2'h0: ssl_presc = 7'h08;
      2'h1: ssl_presc = 7'h10;
      2'h2: ssl_presc = 7'h20;
      default: ssl_presc = 7'h40;
    endcase
  endfunction
endpackage

// [ssl_if.sv]
// three-wire programming link with the test pin, open-drain only in the analog lock modes
`timescale 1ns/1ns
interface ssl_if;
  logic sclk;
  logic sdata;
  logic latch_strobe;
  logic tpin_out;
  logic tpin_oe;
  wire tpin_level;

  // pull-up holds the pin high when nobody drives it
  assign tpin_level = tpin_oe ? tpin_out : 1'b1;

  modport dev (
    input sclk,
    input sdata,
    input latch_strobe,
    output tpin_out,
    output tpin_oe
  );
  modport host (
    output sclk,
    output sdata,
    output latch_strobe,
    input tpin_level
  );
endinterface

// [ssl_sync.sv]
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
module ssl_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk_in,
  // asynchronous levels
  input wire logic [WIDTH-1:0] async_in,
  // synchronised levels
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in) begin
    meta <= async_in;
    sync_out <= meta;
  end
endmodule

// [ssl_device.sv]
// device end: serial shift, latch routing, holding registers, test pin
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module ssl_device
  import ssl_pkg::*;
(
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // programming link
  ssl_if.dev link,
  // lock and monitor sources from the synthesizer cores
  input wire logic rf_lock_in,
  input wire logic rf_pd_pulse_in,
  input wire logic if_lock_in,
  input wire logic if_pd_pulse_in,
  input wire logic rf_div_in,
  input wire logic if_div_in,
  input wire logic ref_div_in,
  // fractional side settings
  output logic [SSL_INT_W-1:0] rf_int_out,
  output logic [SSL_FRAC_W-1:0] rf_frac_out,
  output logic rf_resv_out,
  output logic [SSL_DENOM_W-1:0] rf_denom_out,
  output logic [SSL_RRF_W-1:0] rf_rdiv_out,
  output logic rf_doubler_out,
  output logic rf_prescaler_out,
  output logic [SSL_CTRL_W-1:0] rf_ctrl_out,
  // integer side settings
  output logic [SSL_B_W-1:0] if_b_out,
  output logic [SSL_A_W-1:0] if_a_out,
  output logic [SSL_IPRE_W-1:0] if_prescaler_out,
  output logic [SSL_NRATIO_W-1:0] if_n_ratio_out,
  output logic [SSL_RIF_W-1:0] if_rdiv_out,
  output logic if_doubler_out,
  output logic [SSL_CTRL_W-1:0] if_ctrl_out,
  // master settings
  output logic [SSL_MUX_W-1:0] mux_sel_out,
  output logic xo_disable_out,
  output logic power_down_out,
  output logic cp_tristate_out,
  output logic counter_reset_out,
  output logic ref_connect_out
);
  logic [SSL_WORD_W-1:0] shift;
  logic [SSL_WORD_W-1:0] hold [SSL_NUM_HOLD];
  logic stb_sync;
  logic stb_prev;
  logic [6:0] mon_sync;
  logic [SSL_NRATIO_W-1:0] next_n_ratio;
  logic next_tpin_out;
  logic next_tpin_oe;
  logic tpin_out;
  logic tpin_oe;
  logic ref_connect;

  wire stb_rise;
  wire [SSL_SEL_W-1:0] sel;
  wire rf_lock;
  wire rf_pulse;
  wire if_lock;
  wire if_pulse;
  wire rf_div;
  wire if_div;
  wire ref_div;
  wire [SSL_WORD_W-1:0] w_rfn;
  wire [SSL_WORD_W-1:0] w_rfr;
  wire [SSL_WORD_W-1:0] w_master;
  wire [SSL_WORD_W-1:0] w_ifn;
  wire [SSL_WORD_W-1:0] w_ifr;

  // link domain: serial shift on every rising link clock edge
  always_ff @(posedge link.sclk) begin
    shift <= {shift[SSL_WORD_W-2:0], link.sdata};
  end

  // strobe crosses as a level; the shift word is static while it is high
  ssl_sync #(
    .WIDTH(1)
  ) u_strobe_sync (
    .clk_in(sys_clk_in),
    .async_in(link.latch_strobe),
    .sync_out(stb_sync)
  );

  ssl_sync #(
    .WIDTH(7)
  ) u_mon_sync (
    .clk_in(sys_clk_in),
    .async_in({ref_div_in, if_div_in, rf_div_in, if_pd_pulse_in,
      if_lock_in, rf_pd_pulse_in, rf_lock_in}),
    .sync_out(mon_sync)
  );

  assign rf_lock = mon_sync[0];
  assign rf_pulse = mon_sync[1];
  assign if_lock = mon_sync[2];
  assign if_pulse = mon_sync[3];
  assign rf_div = mon_sync[4];
  assign if_div = mon_sync[5];
  assign ref_div = mon_sync[6];

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      stb_prev <= 1'b0;
    end else begin
      stb_prev <= stb_sync;
    end
  end

  assign stb_rise = stb_sync & ~stb_prev;
  assign sel = shift[SSL_SEL_W-1:0];

  // one holding register per select code; code 111 matches none
  genvar g;
  generate
    for (g = 0; g < SSL_NUM_HOLD; g++) begin : g_hold
      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          hold[g] <= SSL_HOLD_RESET;
        end else if (stb_rise && sel == SSL_SEL_W'(g)) begin
          hold[g] <= shift;
        end
      end
    end
  endgenerate

  assign w_rfn = hold[SSL_SEL_RF_N];
  assign w_rfr = hold[SSL_SEL_RF_R];
  assign w_master = hold[SSL_SEL_MASTER];
  assign w_ifn = hold[SSL_SEL_IF_N];
  assign w_ifr = hold[SSL_SEL_IF_R];

  // fractional feedback word fields
  assign rf_int_out = w_rfn[SSL_INT_LSB +: SSL_INT_W];
  assign rf_resv_out = w_rfn[SSL_RESV_BIT];
  assign rf_frac_out = w_rfn[SSL_FRAC_LSB +: SSL_FRAC_W];

  // comparison rate is ref times (1 + doubler) over this divisor
  assign rf_denom_out = w_rfr[SSL_DENOM_LSB +: SSL_DENOM_W];
  assign rf_rdiv_out = w_rfr[SSL_RRF_LSB +: SSL_RRF_W];
  assign rf_doubler_out = w_rfr[SSL_RF_DBL_BIT];
  assign rf_prescaler_out = w_rfr[SSL_RF_PRE_BIT];
  assign rf_ctrl_out = hold[SSL_SEL_RF_CTRL][SSL_CTRL_LSB +: SSL_CTRL_W];

  // integer side fields
  assign if_a_out = w_ifn[SSL_A_LSB +: SSL_A_W];
  assign if_b_out = w_ifn[SSL_B_LSB +: SSL_B_W];
  assign if_prescaler_out = w_ifn[SSL_IPRE_LSB +: SSL_IPRE_W];
  assign if_rdiv_out = w_ifr[SSL_RIF_LSB +: SSL_RIF_W];
  assign if_doubler_out = w_ifr[SSL_IF_DBL_BIT];
  assign if_ctrl_out = hold[SSL_SEL_IF_CTRL][SSL_CTRL_LSB +: SSL_CTRL_W];

  // master fields
  assign mux_sel_out = w_master[SSL_MUX_LSB +: SSL_MUX_W];
  assign xo_disable_out = w_master[SSL_XO_BIT];
  assign power_down_out = w_master[SSL_PD_BIT];
  assign cp_tristate_out = w_master[SSL_CP3_BIT];
  assign counter_reset_out = w_master[SSL_CRST_BIT];

  // feedback ratio N = P * B + A
  assign next_n_ratio = SSL_NRATIO_W'(
    SSL_NRATIO_W'(ssl_presc(if_prescaler_out)) * SSL_NRATIO_W'(if_b_out)
    + SSL_NRATIO_W'(if_a_out));

  // test pin source; analog lock only ever pulls low
  always_comb begin
    next_tpin_out = 1'b0;
    next_tpin_oe = 1'b1;
    case (mux_sel_out)
      SSL_MUX_RF_DLD: next_tpin_out = rf_lock;
      SSL_MUX_IF_DLD: next_tpin_out = if_lock;
      SSL_MUX_RF_ALD: next_tpin_oe = ~rf_lock | rf_pulse;
      SSL_MUX_IF_ALD: next_tpin_oe = ~if_lock | if_pulse;
      SSL_MUX_RF_DIV: next_tpin_out = rf_div;
      SSL_MUX_IF_DIV: next_tpin_out = if_div;
      SSL_MUX_REF_DIV: next_tpin_out = ref_div;
      default: next_tpin_out = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      if_n_ratio_out <= '0;
      tpin_out <= 1'b0;
      tpin_oe <= 1'b1;
      ref_connect <= 1'b1;
    end else begin
      if_n_ratio_out <= next_n_ratio;
      tpin_out <= next_tpin_out;
      tpin_oe <= next_tpin_oe;
      ref_connect <= ~power_down_out;
    end
  end

  assign link.tpin_out = tpin_out;
  assign link.tpin_oe = tpin_oe;
  assign ref_connect_out = ref_connect;
endmodule

// [ssl_host.sv]
// controller end: register port, serial word sender with divided clock
`timescale 1ns/1ns
module ssl_host
  import ssl_pkg::*;
#(
  parameter int HALF_CYC = SSL_SCLK_HALF_CYC,
  parameter int STB_CYC = SSL_STB_HIGH_CYC
) (
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [SSL_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // programming link
  ssl_if.host link
);
  typedef enum logic [2:0] {
    SSL_ST_IDLE = 3'b001,
    SSL_ST_SHIFT = 3'b010,
    SSL_ST_LATCH = 3'b100
  } ssl_state_t;

  ssl_state_t state;
  logic [SSL_WORD_W-1:0] word;
  logic [SSL_LEN_W-1:0] len;
  logic [SSL_LEN_W-1:0] bit_idx;
  logic [7:0] cnt;
  logic sclk;
  logic sdata;
  logic stb;
  logic done;
  logic pin_sync;

  wire busy = (state != SSL_ST_IDLE);
  wire wr_data = wr_in && addr_in == SSL_REG_DATA;
  wire wr_ctrl = wr_in && addr_in == SSL_REG_CTRL;
  wire wr_stat = wr_in && addr_in == SSL_REG_STATUS;
  wire start = wr_ctrl && wdata_in[SSL_START_BIT] && !busy;
  wire half_end = (cnt == 8'(HALF_CYC - 1));
  wire stb_up = (cnt == 8'(STB_CYC - 1));
  wire stb_end = (cnt == 8'(2 * STB_CYC - 1));
  wire finish = (state == SSL_ST_LATCH) && stb_end;
  wire [SSL_LEN_W-1:0] first_idx = SSL_LEN_W'(wdata_in[SSL_LEN_LSB +:
    SSL_LEN_W] - 1'b1);

  ssl_sync #(
    .WIDTH(1)
  ) u_pin_sync (
    .clk_in(sys_clk_in),
    .async_in(link.tpin_level),
    .sync_out(pin_sync)
  );

  // sender: data changes while the clock is low, device samples on rise
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= SSL_ST_IDLE;
      bit_idx <= '0;
      cnt <= '0;
      sclk <= 1'b0;
      sdata <= 1'b0;
      stb <= 1'b0;
    end else begin
      case (state)
        SSL_ST_IDLE: begin
          cnt <= '0;
          if (start) begin
            state <= SSL_ST_SHIFT;
            bit_idx <= first_idx;
            sdata <= word[first_idx];
          end
        end
        SSL_ST_SHIFT: begin
          cnt <= half_end ? '0 : cnt + 8'h01;
          if (half_end && !sclk) begin
            sclk <= 1'b1;
          end else if (half_end) begin
            sclk <= 1'b0;
            if (bit_idx == '0) begin
              state <= SSL_ST_LATCH;
            end else begin
              bit_idx <= bit_idx - 1'b1;
              sdata <= word[bit_idx - 1'b1];
            end
          end
        end
        SSL_ST_LATCH: begin
          cnt <= cnt + 8'h01;
          if (stb_up) begin
            stb <= 1'b1;
          end
          if (stb_end) begin
            stb <= 1'b0;
            state <= SSL_ST_IDLE;
          end
        end
        default: state <= SSL_ST_IDLE;
      endcase
    end
  end

  // registers; done is sticky, set wins over a clear
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      word <= '0;
      len <= SSL_LEN_RESET;
      done <= 1'b0;
      rdata_out <= '0;
    end else begin
      if (wr_data && !busy) begin
        word <= wdata_in[SSL_WORD_W-1:0];
      end
      if (start) begin
        len <= wdata_in[SSL_LEN_LSB +: SSL_LEN_W];
      end
      if (finish) begin
        done <= 1'b1;
      end else if (wr_stat && wdata_in[SSL_DONE_BIT]) begin
        done <= 1'b0;
      end
      if (rd_in && addr_in == SSL_REG_DATA) begin
        rdata_out <= 32'(word);
      end else if (rd_in && addr_in == SSL_REG_CTRL) begin
        rdata_out <= 32'(len) << SSL_LEN_LSB;
      end else if (rd_in && addr_in == SSL_REG_STATUS) begin
        rdata_out <= 32'({pin_sync, done, busy});
      end else begin
        rdata_out <= '0;
      end
    end
  end

  assign link.sclk = sclk;
  assign link.sdata = sdata;
  assign link.latch_strobe = stb;
endmodule

// [ssl_checker.sv]
// link timing assertions for the serial load port
`timescale 1ns/1ns
module ssl_checker (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // link signals
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch_strobe
);
  logic [4:0] n_rise;

  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // serial clock rises since the last strobe
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || latch_strobe) begin
      n_rise <= 5'h00;
    end else if ($rose(sclk)) begin
      n_rise <= n_rise + 5'h01;
    end
  end

  AST_SCLK_STOPPED_IN_LATCH: assert property (
    latch_strobe |-> !sclk)
    else $error("serial clock high while strobe high");
  AST_DATA_SETUP: assert property (
    $rose(sclk) |-> sdata == $past(sdata, 2))
    else $error("data not settled before clock rise");
  AST_DATA_HOLD: assert property (
    sclk |-> $stable(sdata))
    else $error("data moved while serial clock high");
  AST_SCLK_HIGH_HALF: assert property (
    $rose(sclk) |-> sclk [*2] ##1 !sclk)
    else $error("serial clock high half wrong");
  AST_SCLK_LOW_HALF: assert property (
    $fell(sclk) |-> !sclk [*2])
    else $error("serial clock low half too short");
  AST_STROBE_WIDTH: assert property (
    $rose(latch_strobe) |-> latch_strobe [*3] ##1 !latch_strobe)
    else $error("strobe width wrong");
  AST_WORD_LENGTH: assert property (
    $rose(latch_strobe) |-> n_rise == 5'h18)
    else $error("strobe before a whole word");
  AST_WORD_TO_STROBE: assert property (
    $fell(sclk) && n_rise == 5'h18 |-> ##[1:8] latch_strobe)
    else $error("no strobe after a whole word");
endmodule

// [ssl_tb_top.sv]
// bench joining the controller and the device over the serial link
`timescale 1ns/1ns
module ssl_tb_top
  import ssl_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [SSL_ADDR_W-1:0] addr_in = '0;
  logic [31:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic rf_lock_in = 1'b0, if_lock_in = 1'b0, rf_div_in = 1'b0;
  logic rf_pd_pulse_in = 1'b0, if_pd_pulse_in = 1'b0;
  logic if_div_in = 1'b0, ref_div_in = 1'b0;
  logic [SSL_INT_W-1:0] rf_int_out;
  logic [SSL_FRAC_W-1:0] rf_frac_out;
  logic [SSL_DENOM_W-1:0] rf_denom_out;
  logic [SSL_RRF_W-1:0] rf_rdiv_out;
  logic [SSL_CTRL_W-1:0] rf_ctrl_out, if_ctrl_out;
  logic [SSL_B_W-1:0] if_b_out;
  logic [SSL_A_W-1:0] if_a_out;
  logic [SSL_IPRE_W-1:0] if_prescaler_out;
  logic [SSL_NRATIO_W-1:0] if_n_ratio_out;
  logic [SSL_RIF_W-1:0] if_rdiv_out;
  logic [SSL_MUX_W-1:0] mux_sel_out;
  logic rf_resv_out, rf_doubler_out, rf_prescaler_out, if_doubler_out;
  logic xo_disable_out, power_down_out, cp_tristate_out;
  logic counter_reset_out, ref_connect_out;
  logic [23:0] shadow [7];
  logic [31:0] st;
  logic exp_pin;
  int n_mismatch = 0;
  int n_checks = 0;
  // every select code, field limits, all prescaler codes, one code 7 word
  // denominator goes first; whole value and numerator stay in range
  logic [23:0] rows [15] = '{24'h17fff9, 24'h0fad28, 24'h00a5aa,
    24'h000323, 24'h7ffffc, 24'h07fffd, 24'h00fffe, 24'hffffff,
    24'hfffff8, 24'h088011, 24'h0007fb, 24'h000604, 24'h200a3c,
    24'h40060c, 24'h00000d};

  ssl_if ssl_if_inst ();
  ssl_host #(.HALF_CYC(2), .STB_CYC(3)) ssl_host_inst (.sys_clk_in,
    .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .link(ssl_if_inst));
  ssl_device ssl_device_inst (.sys_clk_in, .sys_rst_in, .link(ssl_if_inst),
    .rf_lock_in, .rf_pd_pulse_in, .if_lock_in, .if_pd_pulse_in, .rf_div_in,
    .if_div_in, .ref_div_in, .rf_int_out, .rf_frac_out, .rf_resv_out,
    .rf_denom_out, .rf_rdiv_out, .rf_doubler_out, .rf_prescaler_out,
    .rf_ctrl_out, .if_b_out, .if_a_out, .if_prescaler_out, .if_n_ratio_out,
    .if_rdiv_out, .if_doubler_out, .if_ctrl_out, .mux_sel_out,
    .xo_disable_out, .power_down_out, .cp_tristate_out, .counter_reset_out,
    .ref_connect_out);
  ssl_checker ssl_checker_inst (.sys_clk_in, .sys_rst_in,
    .sclk(ssl_if_inst.sclk), .sdata(ssl_if_inst.sdata),
    .latch_strobe(ssl_if_inst.latch_strobe));

  always #5 sys_clk_in = ~sys_clk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    @(posedge sys_clk_in);
  endtask

  // full 24-bit word, then start
  task automatic load(input logic [23:0] w);
    wr(SSL_REG_DATA, {8'h00, w});
    wr(SSL_REG_CTRL, 32'h00001801);
  endtask

  // wait for the frame to end, then let the hold registers settle
  task automatic finish();
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd(SSL_REG_STATUS, s);
    chk(s & 32'h3, 32'h2);
    wr(SSL_REG_STATUS, 32'h2);
    rd(SSL_REG_STATUS, s);
    chk(s & 32'h3, 32'h0);
    repeat (8) @(posedge sys_clk_in);
  endtask

  task automatic send(input logic [23:0] w);
    load(w);
    finish();
    if (w[2:0] != SSL_SEL_NONE) shadow[w[2:0]] = w;
  endtask

  task automatic check_all();
    logic [23:0] w;
    logic [18:0] p;
    #1;
    w = shadow[0];
    chk(rf_int_out, w[22:15]);
    chk(rf_frac_out, w[14:3]);
    chk(rf_resv_out, w[23]);
    w = shadow[1];
    chk(rf_denom_out, w[14:3]);
    chk(rf_rdiv_out, w[18:15]);
    chk({rf_prescaler_out, rf_doubler_out}, w[20:19]);
    chk(rf_ctrl_out, shadow[2][15:3]);
    w = shadow[3];
    chk(mux_sel_out, w[10:7]);
    chk({xo_disable_out, power_down_out, cp_tristate_out,
      counter_reset_out}, w[6:3]);
    chk(ref_connect_out, !w[5]);
    w = shadow[4];
    p = 19'h8 << w[22:21];
    chk({if_prescaler_out, if_b_out, if_a_out}, w[22:3]);
    chk(if_n_ratio_out, p * w[20:9] + w[8:3]);
    chk({if_doubler_out, if_rdiv_out}, shadow[5][18:3]);
    chk(if_ctrl_out, shadow[6][15:3]);
    @(posedge sys_clk_in);
  endtask

  task automatic do_reset();
    sys_rst_in <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    foreach (shadow[i]) shadow[i] = '0;
    repeat (3) @(posedge sys_clk_in);
    check_all();
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    @(posedge sys_clk_in);
    do_reset();
    foreach (rows[i]) begin
      send(rows[i]);
      check_all();
      $display("row %0d done", i);
    end
    // every test pin source: idle, active, active with error pulses
    for (int m = 0; m < 8; m++) begin
      send({13'h0000, m[3:0], 7'h03});
      for (int v = 0; v < 3; v++) begin
        rf_lock_in <= v > 0;
        if_lock_in <= v > 0;
        rf_pd_pulse_in <= v == 2;
        if_pd_pulse_in <= v == 2;
        rf_div_in <= v > 0;
        if_div_in <= v > 0;
        ref_div_in <= v > 0;
        repeat (8) @(posedge sys_clk_in);
        exp_pin = v > 0 && m < 7 && !(v == 2 && (m == 1 || m == 3));
        rd(SSL_REG_STATUS, st);
        chk(ssl_if_inst.tpin_level, exp_pin);
        chk(st[SSL_PIN_BIT], exp_pin);
      end
      $display("pin source %0d done", m);
    end
    // second word and start while busy are dropped
    load(24'h000323);
    load(24'h0007fb);
    finish();
    shadow[3] = 24'h000323;
    check_all();
    // the word written while busy must not have replaced the first
    rd(SSL_REG_DATA, st);
    chk(st, 32'h00000323);
    rd(SSL_REG_CTRL, st);
    chk(st, 32'h00001800);
    $display("busy test done");
    do_reset();
    rd(4'hc, st);
    chk(st, 32'h0);
    send(24'h17fff9);
    send(24'h0fad28);
    check_all();
    $display("reset test done");
    end_sim();
  end
endmodule
